// >>> verilog/mip_pkg.sv
// package of constants for the interrupt prioritizer
package mip_pkg;
   // ----------------------------------------
   // register map (byte addresses, one word each)
   // ----------------------------------------
   localparam logic [5:0] MIP_ADDR_MISC = 6'h0C;
   localparam logic [5:0] MIP_ADDR_WAKE = 6'h10;
   localparam logic [5:0] MIP_ADDR_STAT = 6'h14;
   localparam int MIP_ADDR_W = 6;
   // ----------------------------------------
   // misc_control fields, and the wake register enable bit
   // ----------------------------------------
   localparam int MIP_BIT_POR = 7;
   localparam int MIP_BIT_RISE = 6;
   localparam int MIP_BIT_FALL = 5;
   localparam int MIP_BIT_EXT_REQUEST_ENABLE = 4;
   localparam int MIP_BIT_SLOW = 1;
   localparam int MIP_BIT_WATCHDOG_ENABLE_BIT = 0;
   localparam int MIP_BIT_WAKE_EN = 0;
   // ----------------------------------------
   // sources, index 0 is highest priority
   // ----------------------------------------
   localparam int MIP_NSRC = 8;
   localparam int MIP_SRC_RESET = 0;
   localparam int MIP_SRC_SWI = 1;
   localparam int MIP_SRC_EXT = 2;
   localparam int MIP_SRC_CAP = 3;
   localparam int MIP_SRC_CMP = 4;
   localparam int MIP_SRC_OVF = 5;
   localparam int MIP_SRC_SCI = 6;
   localparam int MIP_SRC_CAN = 7;
   localparam logic [15:0] MIP_VEC_RESET = 16'h3FFE;
   localparam logic [15:0] MIP_VEC_STEP = 16'h0002;
   localparam logic [1:0] MIP_SENS_FALL_LOW = 2'h0;
   localparam logic [1:0] MIP_SENS_FALL = 2'h1;
   localparam logic [1:0] MIP_SENS_RISE = 2'h2;
   localparam logic [1:0] MIP_SENS_BOTH = 2'h3;
endpackage

// >>> verilog/mip_ext_detect.sv
// external request combiner and edge/level detector
`timescale 1ns/1ps
module mip_ext_detect
   import mip_pkg::*;
#(
   parameter int N_WAKE = 8
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // pins
   input wire logic i_irq_n,
   input wire logic [N_WAKE-1:0] i_wake_pin,
   input wire logic [N_WAKE-1:0] i_wake_pin_en,
   // control
   input wire logic [1:0] i_sens,
   input wire logic i_clear,
   // result
   output logic o_latched,
   output logic o_level
);
   typedef struct packed {
      logic prev_reg;
      logic wprev_reg;
      logic latch_reg;
   } mip_det_t;
   mip_det_t st_reg, st_next;
   logic wake_any;
   logic ei;
   logic fall;
   logic rise;
   logic hit;
   // ----------------------------------------
   // combining
   // ----------------------------------------
   assign wake_any = |(i_wake_pin & i_wake_pin_en);
   assign ei = wake_any | ~i_irq_n;
   // wake pins use the opposite polarity; ei already inverts the request pin
   always_comb begin
      st_next = st_reg;
      st_next.prev_reg = ei;
      st_next.wprev_reg = wake_any;
      // a wake pin held high masks edges from other pins
      rise = ei & ~st_reg.prev_reg & ~st_reg.wprev_reg;
      fall = ~ei & st_reg.prev_reg & ~wake_any;
      case (i_sens)
         MIP_SENS_FALL_LOW: hit = rise;
         MIP_SENS_FALL: hit = rise;
         MIP_SENS_RISE: hit = fall;
         MIP_SENS_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
      // edge kept even while disabled; clear loses to a new edge
      if (i_clear) begin
         st_next.latch_reg = 1'b0;
      end
      if (hit) begin
         st_next.latch_reg = 1'b1;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign o_latched = st_reg.latch_reg;
   // low level is never latched
   assign o_level = (i_sens == MIP_SENS_FALL_LOW) & ei;
endmodule

// >>> verilog/mip_prioritizer.sv
// interrupt prioritizer top: sources, masking, priority and vectors
// ----------------------------------------
// Operation
// - requests wait; sampled only at instruction boundary strobe.
// - take hardware request only when mask clear and source enabled.
// - on accept, registers stacked then global mask set.
// - return restores mask from the stacked copy.
// - fixed order reset, soft trap, external, capture, compare, overflow, serial, can.
// - vectors 3FFE down to 3FF0 by steps of two.
// - soft trap taken regardless of global mask.
// - soft trap follows requests pending at its fetch, precedes later ones.
// - reset clears all enables except external enable, which it sets.
// - mask set blocks all maskable sources; clearing releases them.
// - bits 6,5 select edge/level sensitivity; reset gives 00.
// - bit 4 enables both request pin and wake pins.
// - sensitivity and enable writes only while mask set.
// - changing sensitivity discards a pending external request.
// - combined request is OR of enabled wake pins and inverted pin.
// - one wake pin high masks further edges on other pins.
// - edge seen while disabled is latched until enabled.
// - latch cleared early in service; low level not latched.
// - wake pin raises request when input, enabled, and option built.
// - reset clears wake enable bit.
// - wake interrupt leaves stop state.
// - wake requests use the external vector pair.
// - reset vectors through 3FFE and sets global mask.
// ----------------------------------------
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module mip_prioritizer
   import mip_pkg::*;
#(
   parameter int N_WAKE = 8,
   parameter bit WAKE_OPTION = 1'b1
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_por,
   // avalon-mm slave
   input wire logic [MIP_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // pins
   input wire logic i_irq_n,
   input wire logic [N_WAKE-1:0] i_wake_pin,
   input wire logic [N_WAKE-1:0] i_wake_pin_is_input,
   // peripheral requests, already gated by their own enables
   input wire logic i_cap_req,
   input wire logic i_cmp_req,
   input wire logic i_ovf_req,
   input wire logic i_sci_req,
   input wire logic i_can_req,
   // cpu core
   input wire logic i_boundary,
   input wire logic i_swi_fetch,
   input wire logic i_ack,
   input wire logic i_rti,
   input wire logic i_stacked_mask,
   input wire logic i_stopped,
   // to cpu core
   output logic o_take,
   output logic [2:0] o_src,
   output logic [15:0] o_vector,
   output logic o_mask,
   output logic o_stack_push,
   output logic o_wake_stop
);
   typedef struct packed {
      logic rst_pend_reg;
      logic mask_reg;
      logic rise_reg;
      logic fall_reg;
      logic ext_request_enable_reg;
      logic por_reg;
      logic slow_reg;
      logic watchdog_enable_bit_reg;
      logic wake_en_reg;
      logic swi_pend_reg;
      logic swi_late_reg;
      logic [MIP_NSRC-1:0] held_reg;
      logic take_reg;
      logic [2:0] src_reg;
      logic [15:0] vec_reg;
      logic push_reg;
      logic wake_reg;
      logic ack_busy_reg;
      logic [31:0] rdata_reg;
      logic wait_reg;
   } mip_state_t;
   mip_state_t st_reg, st_next;
   logic ext_latched;
   logic ext_level;
   logic ext_clear;
   logic [N_WAKE-1:0] wake_gate;
   logic [MIP_NSRC-1:0] pend;
   logic [MIP_NSRC-1:0] enab;
   logic [MIP_NSRC-1:0] elig;
   logic [2:0] win;
   logic any;
   logic wr_misc;
   logic wr_wake;
   logic [1:0] new_sens;
   // ----------------------------------------
   // external detector
   // ----------------------------------------
   // pins configured as outputs never contribute
   assign wake_gate = i_wake_pin_is_input & {N_WAKE{st_reg.wake_en_reg & WAKE_OPTION}};
   mip_ext_detect #(.N_WAKE(N_WAKE)) u_det (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_irq_n(i_irq_n),
      .i_wake_pin(i_wake_pin),
      .i_wake_pin_en(wake_gate),
      .i_sens({st_reg.rise_reg, st_reg.fall_reg}),
      .i_clear(ext_clear),
      .o_latched(ext_latched),
      .o_level(ext_level)
   );
   // ----------------------------------------
   // priority selection
   // ----------------------------------------
   always_comb begin
      pend = '0;
      pend[MIP_SRC_RESET] = st_reg.rst_pend_reg;
      pend[MIP_SRC_SWI] = st_reg.swi_pend_reg;
      pend[MIP_SRC_EXT] = ext_latched | ext_level;
      pend[MIP_SRC_CAP] = i_cap_req;
      pend[MIP_SRC_CMP] = i_cmp_req;
      pend[MIP_SRC_OVF] = i_ovf_req;
      pend[MIP_SRC_SCI] = i_sci_req;
      pend[MIP_SRC_CAN] = i_can_req;
      // reset and soft trap ignore the mask
      enab = {MIP_NSRC{~st_reg.mask_reg}};
      enab[MIP_SRC_RESET] = 1'b1;
      enab[MIP_SRC_SWI] = 1'b1;
      enab[MIP_SRC_EXT] = ~st_reg.mask_reg & st_reg.ext_request_enable_reg;
      elig = pend & enab;
      // soft trap waits behind requests pending before its fetch
      if (st_reg.swi_pend_reg && !st_reg.mask_reg) begin
         elig = elig & ({MIP_NSRC{1'b1}} ^ (pend & ~st_reg.held_reg & ~8'h03));
         if ((elig & st_reg.held_reg & ~8'h03) != '0) begin
            elig[MIP_SRC_SWI] = 1'b0;
         end
      end
      win = '0;
      any = |elig;
      for (int i = MIP_NSRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            win = 3'(i);
         end
      end
   end
   // ----------------------------------------
   // state update
   // ----------------------------------------
   assign wr_misc = i_avs_write && (i_avs_address == MIP_ADDR_MISC) && i_avs_byteenable[0];
   assign wr_wake = i_avs_write && (i_avs_address == MIP_ADDR_WAKE) && i_avs_byteenable[0];
   assign new_sens = {i_avs_writedata[MIP_BIT_RISE], i_avs_writedata[MIP_BIT_FALL]};
   // discard on sensitivity change or on service of the external source
   assign ext_clear = (wr_misc && st_reg.mask_reg && !st_reg.wait_reg
                       && new_sens != {st_reg.rise_reg, st_reg.fall_reg})
                      || (i_ack && st_reg.src_reg == 3'(MIP_SRC_EXT));
   always_comb begin
      st_next = st_reg;
      st_next.push_reg = 1'b0;
      st_next.take_reg = 1'b0;
      // one-cycle wait state gives registered read data
      st_next.wait_reg = (i_avs_read | i_avs_write) & ~st_reg.wait_reg;
      if (i_avs_read && !st_reg.wait_reg) begin
         case (i_avs_address)
            MIP_ADDR_MISC: st_next.rdata_reg = {24'h000000, st_reg.por_reg, st_reg.rise_reg,
               st_reg.fall_reg, st_reg.ext_request_enable_reg, 2'h0, st_reg.slow_reg, st_reg.watchdog_enable_bit_reg};
            MIP_ADDR_WAKE: st_next.rdata_reg = {31'h00000000, st_reg.wake_en_reg};
            MIP_ADDR_STAT: st_next.rdata_reg = {16'h0000, pend, 4'h0, st_reg.mask_reg, win};
            default: st_next.rdata_reg = 32'h00000000;
         endcase
      end
      if (wr_misc && !st_reg.wait_reg) begin
         if (st_reg.mask_reg) begin
            st_next.rise_reg = i_avs_writedata[MIP_BIT_RISE];
            st_next.fall_reg = i_avs_writedata[MIP_BIT_FALL];
            st_next.ext_request_enable_reg = i_avs_writedata[MIP_BIT_EXT_REQUEST_ENABLE];
         end
         // por cleared by writing zero; watchdog bit only settable
         if (!i_avs_writedata[MIP_BIT_POR]) begin
            st_next.por_reg = 1'b0;
         end
         st_next.slow_reg = i_avs_writedata[MIP_BIT_SLOW];
         st_next.watchdog_enable_bit_reg = st_reg.watchdog_enable_bit_reg | i_avs_writedata[MIP_BIT_WATCHDOG_ENABLE_BIT];
      end
      if (wr_wake && !st_reg.wait_reg) begin
         st_next.wake_en_reg = i_avs_writedata[MIP_BIT_WAKE_EN];
      end
      // decision only at the instruction boundary
      if (i_boundary && any && !st_reg.ack_busy_reg) begin
         st_next.take_reg = 1'b1;
         st_next.src_reg = win;
         st_next.vec_reg = MIP_VEC_RESET - 16'(win) * MIP_VEC_STEP;
         st_next.ack_busy_reg = 1'b1;
      end
      if (i_ack && st_reg.ack_busy_reg) begin
         st_next.ack_busy_reg = 1'b0;
         st_next.push_reg = (st_reg.src_reg != 3'(MIP_SRC_RESET));
         st_next.mask_reg = 1'b1;
         if (st_reg.src_reg == 3'(MIP_SRC_RESET)) begin
            st_next.rst_pend_reg = 1'b0;
         end
         if (st_reg.src_reg == 3'(MIP_SRC_SWI)) begin
            st_next.swi_pend_reg = 1'b0;
            st_next.held_reg = '0;
         end
      end else if (i_rti) begin
         st_next.mask_reg = i_stacked_mask;
      end
      // soft trap: snapshot of what was pending at its fetch
      // after the ack, so a new fetch is never lost to the old clear
      if (i_swi_fetch) begin
         st_next.swi_pend_reg = 1'b1;
         st_next.held_reg = pend;
      end
      // power-on flag: the hardware set wins over a software clear
      if (i_por) begin
         st_next.por_reg = 1'b1;
      end
      // wake pin activity restarts the oscillator
      st_next.wake_reg = i_stopped & (|(i_wake_pin & wake_gate)) & st_reg.ext_request_enable_reg;
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
         st_reg.rst_pend_reg <= 1'b1;
         st_reg.mask_reg <= 1'b1;
         st_reg.ext_request_enable_reg <= 1'b1;
         st_reg.wake_en_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_avs_readdata <= 32'h00000000;
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_readdata <= st_next.rdata_reg;
         o_avs_waitrequest <= ~st_next.wait_reg;
      end
   end
   assign o_take = st_reg.take_reg;
   assign o_src = st_reg.src_reg;
   assign o_vector = st_reg.vec_reg;
   assign o_mask = st_reg.mask_reg;
   assign o_stack_push = st_reg.push_reg;
   assign o_wake_stop = st_reg.wake_reg;
endmodule

// >>> bench/mip_prioritizer_sva.sv
// assertion checker for the interrupt prioritizer core side
`timescale 1ns/1ps
module mip_prioritizer_sva
   import mip_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // core inputs
   input wire logic i_boundary,
   input wire logic i_ack,
   input wire logic i_rti,
   input wire logic i_stacked_mask,
   input wire logic i_stopped,
   // core outputs
   input wire logic o_take,
   input wire logic [2:0] o_src,
   input wire logic [15:0] o_vector,
   input wire logic o_mask,
   input wire logic o_stack_push,
   input wire logic o_wake_stop
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // ------
   // properties
   // ------
   property p_take_boundary; o_take |-> $past(i_boundary); endproperty
   a_take_boundary: assert property (p_take_boundary) else $error("take without boundary");
   property p_vec; o_take |-> o_vector == MIP_VEC_RESET - {12'h000, o_src, 1'b0}; endproperty
   a_vec: assert property (p_vec) else $error("vector does not match source");
   property p_ext_vec; o_take && o_src == 3'h2 |-> o_vector == 16'h3FFA; endproperty
   a_ext_vec: assert property (p_ext_vec) else $error("external vector wrong");
   property p_push; i_ack && o_src != 3'h0 |=> o_stack_push && o_mask; endproperty
   a_push: assert property (p_push) else $error("no push or mask after ack");
   property p_reset_src; i_ack && o_src == 3'h0 |=> !o_stack_push && o_mask; endproperty
   a_reset_src: assert property (p_reset_src) else $error("reset entry wrong");
   property p_rti; i_rti |=> o_mask == $past(i_stacked_mask); endproperty
   a_rti: assert property (p_rti) else $error("mask not restored");
   property p_masked; o_take && $past(o_mask) |-> o_src <= 3'h1; endproperty
   a_masked: assert property (p_masked) else $error("maskable taken while masked");
   property p_pulse; o_take |=> !o_take [*2]; endproperty
   a_pulse: assert property (p_pulse) else $error("take repeated");
   property p_wake; o_wake_stop |-> $past(i_stopped); endproperty
   a_wake: assert property (p_wake) else $error("wake flag outside stop");
   c_ext: cover property (o_take && o_src == 3'h2);
   c_swi: cover property (o_take && o_src == 3'h1);
   c_rti: cover property (i_rti ##1 !o_mask);
endmodule

bind mip_prioritizer mip_prioritizer_sva mip_prioritizer_sva_i (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_boundary(i_boundary), .i_ack(i_ack),
   .i_rti(i_rti), .i_stacked_mask(i_stacked_mask), .i_stopped(i_stopped), .o_take(o_take),
   .o_src(o_src), .o_vector(o_vector), .o_mask(o_mask), .o_stack_push(o_stack_push),
   .o_wake_stop(o_wake_stop));

// >>> bench/mip_core_model.sv
// behavioural cpu core driving the prioritizer core side
`timescale 1ns/1ps
module mip_core_model (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // from prioritizer
   input wire logic i_take,
   // to prioritizer
   output logic o_boundary,
   output logic o_swi_fetch,
   output logic o_ack,
   output logic o_rti,
   output logic o_stacked_mask,
   output logic o_stopped
);
   int slow = 0;
   initial begin
      o_boundary = 1'b0;
      o_swi_fetch = 1'b0;
      o_ack = 1'b0;
      o_rti = 1'b0;
      o_stacked_mask = 1'b0;
      o_stopped = 1'b0;
   end
   // slow delays the ack by that many extra cycles after each take
   always @(posedge i_core_clk) begin
      if (i_take === 1'b1 && i_rst_n === 1'b1) begin
         repeat (slow) @(posedge i_core_clk);
         o_ack <= 1'b1;
         @(posedge i_core_clk);
         o_ack <= 1'b0;
      end
   end
   task automatic step();
      @(posedge i_core_clk);
      o_boundary <= 1'b1;
      @(posedge i_core_clk);
      o_boundary <= 1'b0;
   endtask
   task automatic soft_trap_instruction();
      @(posedge i_core_clk);
      o_swi_fetch <= 1'b1;
      @(posedge i_core_clk);
      o_swi_fetch <= 1'b0;
   endtask
   // stacked copy is only valid with the return strobe, so it flips after
   task automatic return_from_trap(input logic m);
      @(posedge i_core_clk);
      o_rti <= 1'b1;
      o_stacked_mask <= m;
      @(posedge i_core_clk);
      o_rti <= 1'b0;
      o_stacked_mask <= ~m;
   endtask
   task automatic stop(input logic s);
      @(posedge i_core_clk);
      o_stopped <= s;
   endtask
endmodule

// >>> bench/testbench.sv
// self-checking testbench for the interrupt prioritizer
`timescale 1ns/1ps
module testbench
   import mip_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, irq_n = 1'b1;
   logic [7:0] wake_pin = 8'h00;
   logic [4:0] periph_req = 5'h00;
   logic por = 1'b0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [7:0] wake_in = 8'hFF;
   logic boundary, swi_fetch, ack, return_from_trap, stacked_mask, stopped;
   logic take, mask, stack_push, wake_stop;
   logic [2:0] src;
   logic [15:0] vector;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   always #5 core_clk = ~core_clk;
   mip_prioritizer mip_prioritizer_i (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_por(por),
      .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
      .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
      .o_avs_readdata(avs_readdata),
      .o_avs_waitrequest(avs_waitrequest), .i_irq_n(irq_n), .i_wake_pin(wake_pin),
      .i_wake_pin_is_input(wake_in), .i_cap_req(periph_req[0]), .i_cmp_req(periph_req[1]),
      .i_ovf_req(periph_req[2]), .i_sci_req(periph_req[3]), .i_can_req(periph_req[4]),
      .i_boundary(boundary), .i_swi_fetch(swi_fetch), .i_ack(ack), .i_rti(return_from_trap),
      .i_stacked_mask(stacked_mask), .i_stopped(stopped), .o_take(take), .o_src(src),
      .o_vector(vector), .o_mask(mask), .o_stack_push(stack_push), .o_wake_stop(wake_stop));
   mip_core_model mip_core_model_i (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_take(take),
      .o_boundary(boundary), .o_swi_fetch(swi_fetch), .o_ack(ack), .o_rti(return_from_trap),
      .o_stacked_mask(stacked_mask), .o_stopped(stopped));
   // ------
   // shared tasks
   // ------
   task automatic report_and_stop();
      if (err_total == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic serve(input logic [2:0] s);
      int n;
      logic pushed;
      n = 0;
      pushed = 1'b0;
      mip_core_model_i.step();
      do begin
         @(negedge core_clk);
         n++;
      end while (take !== 1'b1 && n < 12);
      check({31'h0, take}, 32'h1);
      check({29'h0, src}, {29'h0, s});
      check({16'h0, vector}, {16'h0, 16'h3FFE - {12'h000, s, 1'b0}});
      repeat (6) begin
         @(negedge core_clk);
         if (stack_push === 1'b1) pushed = 1'b1;
      end
      check({31'h0, mask}, 32'h1);
      check({31'h0, pushed}, {31'h0, s != 3'h0});
   endtask
   task automatic no_take();
      logic seen;
      seen = 1'b0;
      mip_core_model_i.step();
      repeat (8) begin
         @(negedge core_clk);
         if (take !== 1'b0) seen = 1'b1;
      end
      check({31'h0, seen}, 32'h0);
   endtask
   task automatic pulse_irq();
      @(posedge core_clk);
      irq_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      irq_n <= 1'b1;
      @(posedge core_clk);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_reset();
      check({31'h0, mask}, 32'h1);
      bus(1'b1, 6'h3C, 8'hFF);
      bus(1'b0, MIP_ADDR_MISC, 8'h00);
      check(rd & 32'h70, 32'h10);
      bus(1'b0, MIP_ADDR_WAKE, 8'h00);
      check(rd, 32'h0);
      serve(3'h0);
   endtask
   task automatic t_priority();
      periph_req <= 5'h1F;
      no_take();
      for (int k = 0; k < 5; k++) begin
         mip_core_model_i.return_from_trap(1'b0);
         serve(3'(k + 3));
         periph_req[k] <= 1'b0;
      end
   endtask
   task automatic t_swi();
      mip_core_model_i.slow = 2;
      periph_req[0] <= 1'b1;
      mip_core_model_i.return_from_trap(1'b0);
      mip_core_model_i.soft_trap_instruction();
      serve(3'h3);
      periph_req[0] <= 1'b0;
      serve(3'h1);
      mip_core_model_i.slow = 0;
   endtask
   task automatic t_ext();
      @(posedge core_clk);
      por <= 1'b1;
      avs_byteenable <= 4'h0;
      @(posedge core_clk);
      por <= 1'b0;
      // lane 0 disabled: the write must leave the register alone
      bus(1'b1, MIP_ADDR_MISC, 8'h30);
      avs_byteenable <= 4'hF;
      bus(1'b0, MIP_ADDR_MISC, 8'h00);
      check(rd & 32'hF0, 32'h90);
      bus(1'b1, MIP_ADDR_MISC, 8'h30);
      pulse_irq();
      mip_core_model_i.return_from_trap(1'b0);
      bus(1'b1, MIP_ADDR_MISC, 8'h50);
      bus(1'b0, MIP_ADDR_MISC, 8'h00);
      check(rd & 32'h70, 32'h30);
      serve(3'h2);
      // rising-only: pin falling alone must not request
      bus(1'b1, MIP_ADDR_MISC, 8'h50);
      irq_n <= 1'b0;
      mip_core_model_i.return_from_trap(1'b0);
      no_take();
      @(posedge core_clk);
      irq_n <= 1'b1;
      serve(3'h2);
      bus(1'b1, MIP_ADDR_MISC, 8'h20);
      pulse_irq();
      bus(1'b1, MIP_ADDR_MISC, 8'h30);
      mip_core_model_i.return_from_trap(1'b0);
      serve(3'h2);
      pulse_irq();
      bus(1'b1, MIP_ADDR_MISC, 8'h70);
      mip_core_model_i.return_from_trap(1'b0);
      no_take();
      bus(1'b1, MIP_ADDR_WAKE, 8'h01);
      wake_in[3] <= 1'b0;
      wake_pin[3] <= 1'b1;
      no_take();
      @(posedge core_clk);
      wake_in[3] <= 1'b1;
      serve(3'h2);
      mip_core_model_i.return_from_trap(1'b0);
      pulse_irq();
      no_take();
      mip_core_model_i.stop(1'b1);
      repeat (3) @(negedge core_clk);
      check({31'h0, wake_stop}, 32'h1);
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      t_reset();
      t_priority();
      t_swi();
      t_ext();
      report_and_stop();
   end
endmodule
